// >>> logic/wss_pkg.sv
// Package with constants and types for the weekly schedule with special days.
package wss_pkg;
  localparam int MAX_ENTRIES = 20;
  localparam int IDX_W = 5;
  localparam logic [IDX_W-1:0] IDX_MAX = 5'h13;
  localparam logic [IDX_W:0] CNT_MAX = 6'h14;
  localparam int DATE_W = 11;
  localparam int TIME_W = 14;
  localparam logic [DATE_W-1:0] DATE_MIN = 11'h065;
  localparam logic [DATE_W-1:0] DATE_MAX = 11'h4CF;
  localparam logic [6:0] MONTH_MIN = 7'h01;
  localparam logic [6:0] MONTH_MAX = 7'h0C;
  localparam logic [6:0] DAY_MIN = 7'h01;
  localparam logic [6:0] DAY_MAX = 7'h1F;
  localparam logic [6:0] HUNDRED = 7'h64;
  localparam logic [6:0] HOUR_MAX = 7'h17;
  localparam logic [6:0] MINUTE_MAX = 7'h3B;
  localparam logic [TIME_W-1:0] TIME_DISABLE = 14'h2710;
  localparam logic [2:0] WEEKDAY_MAX = 3'h6;
  localparam int MASK_W = 7;

  typedef enum logic [1:0] {
    WSS_MODE_PLAIN = 2'h0,
    WSS_MODE_ADD = 2'h1,
    WSS_MODE_SKIP = 2'h2
  } wss_mode_e;

  typedef enum logic [2:0] {
    WSS_ST_IDLE = 3'h1,
    WSS_ST_LOAD = 3'h2,
    WSS_ST_DONE = 3'h4
  } wss_load_st_e;

  typedef struct packed {
    logic [6:0] month;
    logic [6:0] day;
    logic [2:0] weekday;
    logic [6:0] hour;
    logic [6:0] minute;
  } wss_clock_s;

  typedef struct packed {
    logic [1:0] mode;
    logic [MASK_W-1:0] weekday_mask;
    logic [TIME_W-1:0] on_time;
    logic [TIME_W-1:0] off_time;
  } wss_sched_s;
endpackage : wss_pkg

// >>> logic/wss_day_mem.sv
// Small register memory holding the special-day table entries.
`timescale 1ns/1ps
module wss_day_mem #(
  parameter int DEPTH = wss_pkg::MAX_ENTRIES,
  parameter int AW = wss_pkg::IDX_W,
  parameter int DW = wss_pkg::DATE_W
) (
  // Clock and enable
  input wire logic sys_clk,
  input wire logic clk_en,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : wss_day_mem

// >>> logic/wss_time_cmp.sv
// Compares the current hour and minute with one preset switching time.
`timescale 1ns/1ps
module wss_time_cmp (
  // Preset
  input wire logic [wss_pkg::TIME_W-1:0] preset,
  // Current time
  input wire logic [6:0] hour,
  input wire logic [6:0] minute,
  // Result
  output logic hit,
  output logic bad
);
  logic [wss_pkg::TIME_W-1:0] now_code;
  logic [wss_pkg::TIME_W-1:0] hour_part;
  logic [wss_pkg::TIME_W-1:0] min_part;

  assign hour_part = wss_pkg::TIME_W'(preset / wss_pkg::HUNDRED);
  assign min_part = wss_pkg::TIME_W'(preset % wss_pkg::HUNDRED);
  assign now_code = wss_pkg::TIME_W'(hour * wss_pkg::HUNDRED + minute);
  // The disable code never matches and is legal.
  assign hit = (preset != wss_pkg::TIME_DISABLE) && (preset == now_code);
  assign bad = (preset != wss_pkg::TIME_DISABLE) &&
               ((hour_part > wss_pkg::HOUR_MAX) || (min_part > wss_pkg::MINUTE_MAX));
endmodule : wss_time_cmp

// >>> logic/wss_week_sched.sv
// Weekly schedule comparator with a loadable special-day table.
`timescale 1ns/1ps
module wss_week_sched #(
  parameter int MAX_ENTRIES = wss_pkg::MAX_ENTRIES
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Table load
  input wire logic special_day_table_load,
  input wire logic [5:0] load_count,
  input wire logic [wss_pkg::DATE_W-1:0] load_date,
  output logic load_date_take,
  output logic table_busy,
  // Schedule compare
  input wire logic weekly_schedule_compare,
  input wire wss_pkg::wss_sched_s sched,
  input wire wss_pkg::wss_clock_s now,
  // Results
  output logic schedule_output,
  output logic program_error_flag,
  output logic error_led,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h1;
  localparam logic [3:0] REG_STATE = 4'h2;
  localparam int EV_W = 4;
  localparam int EV_ON = 0;
  localparam int EV_OFF = 1;
  localparam int EV_ERR = 2;
  localparam int EV_LOAD = 3;

  wss_pkg::wss_load_st_e load_st;
  wss_pkg::wss_load_st_e next_load_st;
  logic [5:0] load_total;
  logic [wss_pkg::IDX_W-1:0] wr_idx;
  logic [5:0] table_count;
  logic table_loaded;
  logic [wss_pkg::IDX_W-1:0] scan_idx;
  logic [wss_pkg::IDX_W-1:0] scan_idx_q;
  logic scan_valid_q;
  logic [wss_pkg::DATE_W-1:0] scan_date;
  logic [wss_pkg::DATE_W-1:0] today_code;
  logic today_special;
  logic special_acc;
  logic sweep_fresh;
  logic [wss_pkg::DATE_W-1:0] last_today;
  logic on_hit;
  logic off_hit;
  logic on_bad;
  logic off_bad;
  logic day_sel;
  logic yday_sel;
  logic [2:0] yday;
  logic [wss_pkg::TIME_W-1:0] last_min;
  logic [wss_pkg::TIME_W-1:0] now_min;
  logic new_minute;
  logic do_on;
  logic do_off;
  logic date_bad;
  logic sched_bad;
  logic err_event;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] events;

  // Checks a packed month*100+day code against the calendar ranges.
  function automatic logic date_ok(input logic [wss_pkg::DATE_W-1:0] d);
    logic [wss_pkg::DATE_W-1:0] mo;
    logic [wss_pkg::DATE_W-1:0] dy;
    mo = wss_pkg::DATE_W'(d / wss_pkg::HUNDRED);
    dy = wss_pkg::DATE_W'(d % wss_pkg::HUNDRED);
    date_ok = (mo >= wss_pkg::DATE_W'(wss_pkg::MONTH_MIN)) &&
              (mo <= wss_pkg::DATE_W'(wss_pkg::MONTH_MAX)) &&
              (dy >= wss_pkg::DATE_W'(wss_pkg::DAY_MIN)) &&
              (dy <= wss_pkg::DATE_W'(wss_pkg::DAY_MAX));
  endfunction : date_ok

  // Tells whether a weekday is selected by the mask.
  function automatic logic day_in_mask(input logic [wss_pkg::MASK_W-1:0] m,
                                       input logic [2:0] wd);
    day_in_mask = (wd <= wss_pkg::WEEKDAY_MAX) && m[wd];
  endfunction : day_in_mask

  // Table load sequencer.
  always_comb begin
    next_load_st = load_st;
    case (load_st)
      wss_pkg::WSS_ST_IDLE: begin
        if (special_day_table_load && (load_count != 6'h00) &&
            (load_count <= wss_pkg::CNT_MAX)) begin
          next_load_st = wss_pkg::WSS_ST_LOAD;
        end
      end
      wss_pkg::WSS_ST_LOAD: begin
        if (wr_idx == wss_pkg::IDX_W'(load_total - 6'h01)) begin
          next_load_st = wss_pkg::WSS_ST_DONE;
        end
      end
      wss_pkg::WSS_ST_DONE: begin
        if (!special_day_table_load) begin
          next_load_st = wss_pkg::WSS_ST_IDLE;
        end
      end
      default: next_load_st = wss_pkg::WSS_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      load_st <= wss_pkg::WSS_ST_IDLE;
    end else if (clk_en) begin
      load_st <= next_load_st;
    end
  end

  assign load_date_take = (load_st == wss_pkg::WSS_ST_LOAD);
  assign table_busy = (load_st != wss_pkg::WSS_ST_IDLE);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_idx <= '0;
      load_total <= '0;
      table_count <= '0;
      table_loaded <= 1'b0;
    end else if (clk_en) begin
      if (load_st == wss_pkg::WSS_ST_IDLE && next_load_st == wss_pkg::WSS_ST_LOAD) begin
        load_total <= load_count;
        wr_idx <= '0;
        table_loaded <= 1'b0;
      end else if (load_st == wss_pkg::WSS_ST_LOAD) begin
        wr_idx <= wr_idx + 1'b1;
        if (next_load_st == wss_pkg::WSS_ST_DONE) begin
          table_count <= load_total;
          table_loaded <= 1'b1;
        end
      end
    end
  end

  assign date_bad = load_date_take && !date_ok(load_date);

  wss_day_mem #(
    .DEPTH(MAX_ENTRIES),
    .AW(wss_pkg::IDX_W),
    .DW(wss_pkg::DATE_W)
  ) u_mem (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .wr_en(load_date_take),
    .wr_addr(wr_idx),
    .wr_data(load_date),
    .rd_addr(scan_idx),
    .rd_data(scan_date)
  );

  // The table is scanned continuously; a full sweep settles today's flag.
  // A sweep that saw the date change part way through holds stale matches,
  // so only a sweep that started on the current date may publish its result.
  assign today_code = wss_pkg::DATE_W'(now.month * wss_pkg::HUNDRED + now.day);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scan_idx <= '0;
      scan_idx_q <= '0;
      scan_valid_q <= 1'b0;
      special_acc <= 1'b0;
      today_special <= 1'b0;
      last_today <= '0;
      sweep_fresh <= 1'b0;
    end else if (clk_en) begin
      scan_idx <= (scan_idx == wss_pkg::IDX_MAX) ? '0 : scan_idx + 1'b1;
      scan_idx_q <= scan_idx;
      scan_valid_q <= 1'b1;
      last_today <= today_code;
      if (last_today != today_code) begin
        today_special <= 1'b0;
      end
      if (scan_valid_q) begin
        if (scan_idx_q == '0) begin
          special_acc <= table_loaded && (table_count != 6'h00) && (scan_date == today_code);
          sweep_fresh <= 1'b1;
        end else if ((6'(scan_idx_q) < table_count) && table_loaded &&
                     (scan_date == today_code)) begin
          special_acc <= 1'b1;
        end
        if (scan_idx_q == wss_pkg::IDX_MAX && last_today == today_code && sweep_fresh) begin
          today_special <= special_acc ||
                           ((6'(scan_idx_q) < table_count) && table_loaded &&
                            (scan_date == today_code));
        end
      end
      // A date change discards the sweep in progress.
      if (last_today != today_code) begin
        sweep_fresh <= 1'b0;
      end
    end
  end

  wss_time_cmp u_on_cmp (
    .preset(sched.on_time),
    .hour(now.hour),
    .minute(now.minute),
    .hit(on_hit),
    .bad(on_bad)
  );

  wss_time_cmp u_off_cmp (
    .preset(sched.off_time),
    .hour(now.hour),
    .minute(now.minute),
    .hit(off_hit),
    .bad(off_bad)
  );

  assign now_min = wss_pkg::TIME_W'(now.hour * wss_pkg::HUNDRED + now.minute);
  assign yday = (now.weekday == 3'h0) ? wss_pkg::WEEKDAY_MAX : now.weekday - 3'h1;

  // Day qualification per mode; special days override the weekday mask for the current day only (not yday_sel) in the add and skip modes.
  always_comb begin
    day_sel = day_in_mask(sched.weekday_mask, now.weekday);
    yday_sel = day_in_mask(sched.weekday_mask, yday);
    case (sched.mode)
      wss_pkg::WSS_MODE_ADD: day_sel = day_sel || today_special;
      wss_pkg::WSS_MODE_SKIP: day_sel = day_sel && !today_special;
      default: day_sel = day_sel;
    endcase
  end

  assign sched_bad = (sched.mode > 2'(wss_pkg::WSS_MODE_SKIP)) || on_bad || off_bad ||
                     ((sched.mode != 2'(wss_pkg::WSS_MODE_PLAIN)) && !table_loaded);
  assign new_minute = weekly_schedule_compare && (now_min != last_min);
  assign do_on = new_minute && !sched_bad && on_hit && day_sel;
  // An overnight span ends on the day after a selected day.
  assign do_off = new_minute && !sched_bad && off_hit &&
                  ((sched.on_time > sched.off_time && sched.on_time != wss_pkg::TIME_DISABLE)
                   ? (yday_sel || day_sel) : day_sel);
  assign err_event = date_bad || (weekly_schedule_compare && sched_bad);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      last_min <= wss_pkg::TIME_DISABLE;
      schedule_output <= 1'b0;
    end else if (clk_en) begin
      if (weekly_schedule_compare) begin
        last_min <= now_min;
      end
      if (do_on) begin
        schedule_output <= 1'b1;
      end else if (do_off) begin
        schedule_output <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      program_error_flag <= 1'b0;
      error_led <= 1'b0;
    end else if (clk_en) begin
      if (err_event) begin
        program_error_flag <= 1'b1;
        error_led <= 1'b1;
      end else if (reg_wr && reg_addr == REG_STATE && reg_wdata[0]) begin
        program_error_flag <= 1'b0;
        error_led <= 1'b0;
      end
    end
  end

  assign events = {load_st == wss_pkg::WSS_ST_LOAD && next_load_st == wss_pkg::WSS_ST_DONE,
                   err_event, do_off && !do_on, do_on};

  // Sticky status, cleared by reading it; a new event wins over the clear.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status <= '0;
      irq_mask <= '0;
      reg_rdata <= '0;
    end else if (clk_en) begin
      status <= ((reg_rd && reg_addr == REG_STATUS) ? '0 : status) | events;
      if (reg_wr && reg_addr == REG_MASK) begin
        irq_mask <= reg_wdata[EV_W-1:0];
      end
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          REG_STATUS: reg_rdata <= {28'h0000000, status};
          REG_MASK: reg_rdata <= {28'h0000000, irq_mask};
          REG_STATE: reg_rdata <= {16'h0000, 2'h0, table_count, 3'h0, table_loaded,
                                   1'b0, table_busy, schedule_output, program_error_flag};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  assign irq = |(status & irq_mask);
endmodule : wss_week_sched

// >>> verification/wss_week_sched_props.sv
// Port checker for the weekly schedule block.
`timescale 1ns/1ps
module wss_sched_chk #(
  parameter int MAX_ENTRIES = wss_pkg::MAX_ENTRIES
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Table load
  input wire logic special_day_table_load,
  input wire logic [5:0] load_count,
  input wire logic [wss_pkg::DATE_W-1:0] load_date,
  input wire logic load_date_take,
  input wire logic table_busy,
  // Compare and results
  input wire logic weekly_schedule_compare,
  input wire wss_pkg::wss_sched_s sched,
  input wire wss_pkg::wss_clock_s now,
  input wire logic schedule_output,
  input wire logic program_error_flag,
  input wire logic error_led,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq
);
  logic [5:0] take_run;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // Length of the current run of consecutive entry takes.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      take_run <= 6'h00;
    end else if (clk_en) begin
      take_run <= load_date_take ? take_run + 6'h01 : 6'h00;
    end
  end
  out_cause_a: assert property (schedule_output != $past(schedule_output) |->
    $past(weekly_schedule_compare)) else $error("output moved without a compare");
  flag_hold_a: assert property (program_error_flag &&
    !(reg_wr && reg_addr == 4'h2 && reg_wdata[0]) |=> program_error_flag)
    else $error("error flag dropped on its own");
  flag_cause_a: assert property ($rose(program_error_flag) |->
    $past(weekly_schedule_compare || load_date_take)) else $error("error flag without cause");
  led_follow_a: assert property (error_led == program_error_flag)
    else $error("error indicator differs from flag");
  take_start_a: assert property ($rose(special_day_table_load) && clk_en && !table_busy &&
    load_count inside {[6'h01:6'h14]} |=> load_date_take) else $error("load did not start");
  take_busy_a: assert property (load_date_take |-> table_busy)
    else $error("entry taken while idle");
  take_max_a: assert property (take_run <= 6'(MAX_ENTRIES))
    else $error("more entries taken than allowed");
  rdata_idle_a: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  freeze_all_a: assert property (!clk_en |=> $stable(schedule_output) && $stable(program_error_flag))
    else $error("state moved while frozen");
  both_off_a: assert property (weekly_schedule_compare && !$past(weekly_schedule_compare) &&
    sched.on_time == wss_pkg::TIME_DISABLE && sched.off_time == wss_pkg::TIME_DISABLE
    |=> $stable(schedule_output)) else $error("disabled times switched output");
  reset_zero_a: assert property (disable iff (1'b0) sys_rst && clk_en |=>
    !schedule_output && !program_error_flag && !irq) else $error("outputs not cleared by reset");
  on_c: cover property ($rose(schedule_output));
  err_c: cover property ($rose(program_error_flag));
  load_c: cover property ($fell(load_date_take));
endmodule : wss_sched_chk
bind wss_week_sched wss_sched_chk #(.MAX_ENTRIES(MAX_ENTRIES)) chk_inst (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .special_day_table_load(special_day_table_load), .load_count(load_count),
  .load_date(load_date), .load_date_take(load_date_take), .table_busy(table_busy),
  .weekly_schedule_compare(weekly_schedule_compare), .sched(sched), .now(now),
  .schedule_output(schedule_output), .program_error_flag(program_error_flag),
  .error_led(error_led), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
);

// >>> verification/tb_top.sv
// Self-checking bench for the weekly schedule block.
`timescale 1ns/1ps
module tb_top;
  typedef struct {int md, mk, on, off, mo, dy, wd, hh, mi; logic q;} wss_row_s;
  logic sys_clk, sys_rst, clk_en, ld, tk, busy, cmp, q, flag, led, wr, rd, irq;
  logic [5:0] cnt;
  logic [10:0] date;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  wss_pkg::wss_sched_s sched;
  wss_pkg::wss_clock_s now;
  int error_cnt, tests_run, k, takes;
  int tbl[4] = '{1231, 101, 102, 103};
  // Mode, mask, on, off, month, day, weekday, hour, minute, expected output.
  wss_row_s rows[12] = '{
    '{0, 62, 830, 1715, 6, 1, 1, 8, 30, 1},
    '{0, 62, 830, 1715, 6, 1, 1, 17, 15, 0},
    '{0, 62, 830, 1715, 6, 7, 0, 8, 30, 0},
    '{1, 65, 1031, 2310, 12, 31, 3, 10, 31, 1},
    '{1, 65, 1031, 2310, 12, 31, 3, 23, 10, 0},
    '{2, 62, 1000, 2005, 1, 5, 1, 10, 0, 1},
    '{2, 62, 1000, 2005, 1, 1, 1, 20, 5, 1},
    '{0, 2, 2301, 110, 1, 6, 2, 1, 10, 0},
    '{0, 2, 2301, 110, 1, 5, 1, 23, 1, 1},
    '{0, 2, 2301, 110, 1, 6, 2, 1, 10, 0},
    '{0, 127, 10000, 10000, 1, 7, 3, 10, 30, 0},
    '{0, 127, 1200, 10000, 1, 7, 3, 12, 0, 1}};
  assign date = 11'(tbl[k]);
  wss_week_sched wss_week_sched_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .special_day_table_load(ld), .load_count(cnt), .load_date(date),
    .load_date_take(tk), .table_busy(busy), .weekly_schedule_compare(cmp),
    .sched(sched), .now(now), .schedule_output(q), .program_error_flag(flag),
    .error_led(led), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .irq(irq));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (tk) begin
    k <= k + 1;
    takes <= takes + 1;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic chk1(string nm, logic e, logic s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, e, s);
    end
  endtask : chk1
  task automatic chk32(string nm, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk32
  task automatic wreg(logic [3:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(string nm, logic [3:0] a, logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    cyc(1);
    chk32(nm, e, rdata);
  endtask : rreg
  task automatic load(int n);
    k = 0;
    takes = 0;
    cnt <= 6'(n);
    ld <= 1'b1;
    cyc(n + 3);
    chk1("load busy", n != 0, busy);
    ld <= 1'b0;
    cyc(2);
    chk1("load idle", 1'b0, busy);
    chk32("entries taken", 32'(n), 32'(takes));
  endtask : load
  // Waits out two special-day sweeps before one compare pulse.
  task automatic run_row(wss_row_s r);
    sched <= {2'(r.md), 7'(r.mk), 14'(r.on), 14'(r.off)};
    now <= {7'(r.mo), 7'(r.dy), 3'(r.wd), 7'(r.hh), 7'(r.mi)};
    cyc(42);
    cmp <= 1'b1;
    cyc(1);
    cmp <= 1'b0;
    cyc(2);
    chk1("schedule_output", r.q, q);
  endtask : run_row
  task automatic test_done;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
  initial begin
    {sys_rst, clk_en, ld, cmp, wr, rd} = 6'h30;
    {cnt, addr, wdata, sched, now} = '0;
    error_cnt = 0;
    tests_run = 0;
    k = 0;
    takes = 0;
    cyc(5);
    sys_rst <= 1'b0;
    cyc(1);
    chk1("reset output", 1'b0, q);
    chk1("reset flag", 1'b0, flag);
    wreg(4'h1, 32'h0000000F);
    rreg("mask", 4'h1, 32'h0000000F);
    rreg("unmapped", 4'hB, 32'h00000000);
    load(4);
    rreg("status", 4'h0, 32'h00000008);
    rreg("state", 4'h2, 32'h00000410);
    foreach (rows[i]) run_row(rows[i]);
    run_row('{0, 32, 10000, 1900, 1, 9, 5, 19, 0, 0});
    run_row('{0, 2, 800, 10000, 1, 12, 1, 8, 0, 1});
    run_row('{0, 32, 10000, 1900, 1, 14, 3, 19, 0, 1});
    chk1("irq", 1'b1, irq);
    wreg(4'h1, 32'h00000000);
    cyc(1);
    chk1("masked irq", 1'b0, irq);
    rreg("events", 4'h0, 32'h00000003);
    clk_en <= 1'b0;
    run_row('{0, 127, 10000, 1230, 1, 7, 3, 12, 30, 1});
    clk_en <= 1'b1;
    tbl[3] = 1300;
    load(4);
    chk1("bad entry flag", 1'b1, flag);
    chk1("bad entry led", 1'b1, led);
    wreg(4'h2, 32'h00000001);
    cyc(1);
    chk1("flag cleared", 1'b0, flag);
    load(0);
    run_row('{0, 127, 2460, 10000, 1, 7, 3, 12, 0, 1});
    chk1("bad time flag", 1'b1, flag);
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    run_row('{1, 65, 1031, 2310, 12, 31, 3, 10, 31, 0});
    chk1("no table flag", 1'b1, flag);
    test_done();
  end
endmodule : tb_top
